// ==== design/adc_datapath_consts.vh ====
// constants for the sample path control block
`ifndef ADC_DATAPATH_CONSTS_VH
`define ADC_DATAPATH_CONSTS_VH
`define ADDR_SWAP_MUX_DELAY 12'h09b
`define ADDR_DITHER_CONTROL 12'h09d
`define ADDR_SAMPLE_LSB_CONTROL 12'h160
`define RST_SWAP_MUX_DELAY 5'h07
`define RST_DITHER_CONTROL 3'h0
`define RST_SAMPLE_LSB_CONTROL 1'h0
`define BIT_DITHER_ENABLE 0
`define BIT_DITHER_AMPLITUDE 1
`define BIT_ROUNDING_TARGET 2
`define BIT_TIMESTAMP_INSERT 0
`define SAMPLE_WIDTH 12
`define LINK_WIDTH 16
`define TIMESTAMP_LATENCY 4
`endif

// ==== design/adc_datapath_swap_dither_timestamp_ctrl.v ====
// register bank and sample path control for swap mux, dither and timestamp
//
// Function
// [R1] A five-bit swap mux delay register takes any value 0 to 31 and resets to 7.
// [R2] The delayed selection steers which core sample stream feeds each encoder.
// [R3] The programmed delay is used only while a background swap is in progress.
// [R4] Software tunes the delay so the switch falls where both streams are valid.
// [R5] Dither control bit 0, reset 0, enables converter dither.
// [R6] Dither control bit 1 selects small (0) or large (1) dither amplitude.
// [R7] Dither control bit 2 picks whether rounding error hits SNR or offset and spurs.
// [R8] Software writes reserved bits with their reset value of zero.
// [R9] Sample control bit 0 puts the timestamp input on the sample lsb.
// [R10] Timestamp latency through the block equals that of the samples.
// [R11] With a wider link field the timestamp takes the extra lsb, not the sample lsb.
// [R12] The lane alignment control-bit count always reports zero.
// [R13] Software enables the timestamp receiver whenever insertion is enabled.
`include "adc_datapath_consts.vh"

// ****************************************
// three-flop synchroniser with agree filter
// ****************************************
module pin_sync_filter #(
  parameter RESET_VALUE = 1'b0
) (
  // clock and reset
  input wire clk_sys,
  input wire reset_n,
  // raw and filtered level
  input wire pinLevel,
  output reg filteredLevel
);

  reg syncStage1;
  reg syncStage2;
  reg syncStage3;

  // change counts once second and third flop agree
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      syncStage1 <= RESET_VALUE;
      syncStage2 <= RESET_VALUE;
      syncStage3 <= RESET_VALUE;
      filteredLevel <= RESET_VALUE;
    end else begin
      syncStage1 <= pinLevel;
      syncStage2 <= syncStage1;
      syncStage3 <= syncStage2;
      if (syncStage2 == syncStage3) begin
        filteredLevel <= syncStage3;
      end
    end
  end

endmodule

// ****************************************
// fixed-length sample delay line
// ****************************************
module sample_delay_line #(
  parameter WIDTH = 12,
  parameter DEPTH = 4
) (
  // clock and reset
  input wire clk_sys,
  input wire reset_n,
  // sample in and delayed sample out
  input wire [WIDTH-1:0] sampleIn,
  output wire [WIDTH-1:0] sampleOut
);

  reg [WIDTH-1:0] stage [0:DEPTH-1];
  integer i;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        stage[i] <= {WIDTH{1'b0}};
      end
    end else begin
      stage[0] <= sampleIn;
      for (i = 1; i < DEPTH; i = i + 1) begin
        stage[i] <= stage[i-1];
      end
    end
  end

  assign sampleOut = stage[DEPTH-1];

endmodule

module adc_datapath_swap_dither_timestamp_ctrl (
  // clock and reset
  input wire clk_sys,
  input wire reset_n,
  // register port
  input wire [11:0] regAddr,
  input wire [7:0] regWriteData,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regReadData,
  // swap control
  input wire swapActive,
  input wire muxSelect,
  output reg encoderSelect,
  // core samples and timestamp
  input wire [11:0] coreSampleA,
  input wire [11:0] coreSampleB,
  input wire timestampIn,
  output reg [15:0] linkSample0,
  output reg [15:0] linkSample1,
  // dither and alignment settings
  output reg ditherEnable,
  output reg ditherAmplitudeSelect,
  output reg roundingErrorTarget,
  output reg [1:0] alignControlBits
);

  // ****************************************
  // registers
  // ****************************************
  reg [4:0] swapMuxDelay;
  reg [2:0] ditherControl;
  reg timestampInsertEnable;
  reg [4:0] next_swapMuxDelay;
  reg [2:0] next_ditherControl;
  reg next_timestampInsertEnable;
  wire writeSwapDelay;
  wire writeDither;
  wire writeLsbControl;

  // ****************************************
  // register decode
  // ****************************************
  // exact address decode, unmapped writes dropped
  assign writeSwapDelay = regWrite && (regAddr == `ADDR_SWAP_MUX_DELAY);
  assign writeDither = regWrite && (regAddr == `ADDR_DITHER_CONTROL);
  assign writeLsbControl = regWrite && (regAddr == `ADDR_SAMPLE_LSB_CONTROL);

  // reserved bits not stored
  always @* begin
    next_swapMuxDelay = swapMuxDelay;
    next_ditherControl = ditherControl;
    next_timestampInsertEnable = timestampInsertEnable;
    if (writeSwapDelay) begin
      next_swapMuxDelay = regWriteData[4:0]; // see [R1]
    end
    if (writeDither) begin
      next_ditherControl = regWriteData[2:0]; // see [R5] see [R6] see [R7]
    end
    if (writeLsbControl) begin
      next_timestampInsertEnable = regWriteData[`BIT_TIMESTAMP_INSERT]; // see [R9]
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      swapMuxDelay <= `RST_SWAP_MUX_DELAY; // see [R1]
      ditherControl <= `RST_DITHER_CONTROL;
      timestampInsertEnable <= `RST_SAMPLE_LSB_CONTROL;
    end else begin
      swapMuxDelay <= next_swapMuxDelay;
      ditherControl <= next_ditherControl;
      timestampInsertEnable <= next_timestampInsertEnable;
    end
  end

  // ****************************************
  // read port
  // ****************************************
  reg [7:0] next_regReadData;

  // unmapped reads and reserved bits read zero
  always @* begin
    next_regReadData = 8'h00;
    if (regRead) begin
      case (regAddr)
        `ADDR_SWAP_MUX_DELAY: next_regReadData = {3'h0, swapMuxDelay};
        `ADDR_DITHER_CONTROL: next_regReadData = {5'h00, ditherControl};
        `ADDR_SAMPLE_LSB_CONTROL: next_regReadData = {7'h00, timestampInsertEnable};
        default: next_regReadData = 8'h00;
      endcase
    end
  end

  // data stand one cycle after the strobe only
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      regReadData <= 8'h00;
    end else begin
      regReadData <= next_regReadData;
    end
  end

  // ****************************************
  // dither settings
  // ****************************************
  reg next_ditherEnable;
  reg next_ditherAmplitudeSelect;
  reg next_roundingErrorTarget;

  always @* begin
    next_ditherEnable = ditherControl[`BIT_DITHER_ENABLE]; // see [R5]
    next_ditherAmplitudeSelect = ditherControl[`BIT_DITHER_AMPLITUDE]; // see [R6]
    next_roundingErrorTarget = ditherControl[`BIT_ROUNDING_TARGET]; // see [R7]
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ditherEnable <= 1'b0;
      ditherAmplitudeSelect <= 1'b0;
      roundingErrorTarget <= 1'b0;
      alignControlBits <= 2'h0;
    end else begin
      ditherEnable <= next_ditherEnable;
      ditherAmplitudeSelect <= next_ditherAmplitudeSelect;
      roundingErrorTarget <= next_roundingErrorTarget;
      alignControlBits <= 2'h0; // see [R12]
    end
  end

  // ****************************************
  // synchronisers
  // ****************************************
  wire swapState;
  wire selState;
  wire stampState;

  // swap flag, selection and timestamp come from outside the clock domain
  pin_sync_filter #(
    .RESET_VALUE(1'b0)
  ) swapSync_u (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pinLevel(swapActive),
    .filteredLevel(swapState)
  );

  pin_sync_filter #(
    .RESET_VALUE(1'b0)
  ) selSync_u (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pinLevel(muxSelect),
    .filteredLevel(selState)
  );

  pin_sync_filter #(
    .RESET_VALUE(1'b0)
  ) stampSync_u (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pinLevel(timestampIn),
    .filteredLevel(stampState)
  );

  // ****************************************
  // swap mux selection delay
  // ****************************************
  reg [31:0] selectHistory;
  wire [4:0] tapIndex;
  wire delayedSelect;
  reg next_encoderSelect;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      selectHistory <= 32'h00000000;
    end else begin
      selectHistory <= {selectHistory[30:0], selState};
    end
  end

  // tap n-1 is n cycles older; delay 0 bypasses the history
  assign tapIndex = swapMuxDelay - 5'h01;
  assign delayedSelect = (swapMuxDelay == 5'h00) ? selState : selectHistory[tapIndex]; // see [R1]

  always @* begin
    next_encoderSelect = selState; // see [R3]
    if (swapState) begin
      next_encoderSelect = delayedSelect; // see [R3]
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      encoderSelect <= 1'b0;
    end else begin
      encoderSelect <= next_encoderSelect; // see [R2]
    end
  end

  // ****************************************
  // sample delay and timestamp insertion
  // ****************************************
  wire [11:0] tailA;
  wire [11:0] tailB;
  wire stampBit;

  // samples wait the same stages as the timestamp synchroniser
  sample_delay_line #(
    .WIDTH(`SAMPLE_WIDTH),
    .DEPTH(`TIMESTAMP_LATENCY)
  ) delayA_u (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .sampleIn(coreSampleA),
    .sampleOut(tailA)
  );

  sample_delay_line #(
    .WIDTH(`SAMPLE_WIDTH),
    .DEPTH(`TIMESTAMP_LATENCY)
  ) delayB_u (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .sampleIn(coreSampleB),
    .sampleOut(tailB)
  );

  assign stampBit = stampState & timestampInsertEnable; // see [R9] see [R10]

  // ****************************************
  // link output
  // ****************************************
  reg [15:0] next_linkSample0;
  reg [15:0] next_linkSample1;

  // sample, zero pad, then stamp in the extra lsb
  always @* begin
    next_linkSample0 = {tailA, 3'h0, stampBit}; // see [R11]
    next_linkSample1 = {tailB, 3'h0, stampBit}; // see [R11]
    if (encoderSelect) begin
      next_linkSample0 = {tailB, 3'h0, stampBit}; // see [R2]
      next_linkSample1 = {tailA, 3'h0, stampBit}; // see [R2]
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      linkSample0 <= 16'h0000;
      linkSample1 <= 16'h0000;
    end else begin
      linkSample0 <= next_linkSample0; // see [R10]
      linkSample1 <= next_linkSample1;
    end
  end

endmodule

// ==== verification/adc_datapath_ctrl_monitor.sv ====
// assertions for the sample path control block
module adc_datapath_ctrl_monitor (
  // clock and reset
  input wire clk_sys,
  input wire reset_n,
  // register port
  input wire [11:0] regAddr,
  input wire [7:0] regWriteData,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regReadData,
  // sample path
  input wire swapActive,
  input wire muxSelect,
  input wire encoderSelect,
  input wire [11:0] coreSampleA,
  input wire [11:0] coreSampleB,
  input wire [15:0] linkSample0,
  input wire [15:0] linkSample1,
  input wire ditherEnable,
  input wire ditherAmplitudeSelect,
  input wire roundingErrorTarget,
  input wire [1:0] alignControlBits
);
  timeunit 1ns;
  timeprecision 1ns;
  wire dw = regWrite && regAddr == 12'h09d;
  wire lw = regWrite && regAddr == 12'h09b;
  wire lr = regRead && regAddr == 12'h09b;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_en; dw |-> ##2 ditherEnable == $past(regWriteData[0], 2); endproperty
  a_en: assert property (p_en) else $error("dither enable");
  property p_amp; dw |-> ##2 ditherAmplitudeSelect == $past(regWriteData[1], 2); endproperty
  a_amp: assert property (p_amp) else $error("dither amplitude");
  property p_err; dw |-> ##2 roundingErrorTarget == $past(regWriteData[2], 2); endproperty
  a_err: assert property (p_err) else $error("rounding target");
  property p_rd; lw ##2 lr |=> regReadData == {3'h0, $past(regWriteData[4:0], 3)}; endproperty
  a_rd: assert property (p_rd) else $error("delay readback");
  property p_sel; (!swapActive && $stable(muxSelect)) [*8] |-> encoderSelect == muxSelect; endproperty
  a_sel: assert property (p_sel) else $error("select path");
  property p_samp; $past(reset_n, 5) |-> linkSample0[15:4] == $past(coreSampleA, 5)
    || linkSample0[15:4] == $past(coreSampleB, 5); endproperty
  a_samp: assert property (p_samp) else $error("sample latency");
  property p_pad; linkSample0[3:1] == 3'h0 && linkSample1[3:1] == 3'h0; endproperty
  a_pad: assert property (p_pad) else $error("pad bits");
  property p_cs; alignControlBits == 2'h0; endproperty
  a_cs: assert property (p_cs) else $error("control bits");
endmodule
bind adc_datapath_swap_dither_timestamp_ctrl adc_datapath_ctrl_monitor mon_u (.*);

// ==== verification/tb_adc_datapath_swap_dither_timestamp_ctrl.sv ====
// self-checking testbench for the sample path control block
module tb_adc_datapath_swap_dither_timestamp_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, reset_n, regWrite, regRead, swapActive, muxSelect, timestampIn, encoderSelect;
  logic ditherEnable, ditherAmplitudeSelect, roundingErrorTarget;
  logic [11:0] regAddr, coreSampleA, coreSampleB;
  logic [7:0] regWriteData, regReadData;
  logic [15:0] linkSample0, linkSample1;
  logic [1:0] alignControlBits;
  int miscompares = 0;
  int n_checks = 0;
  adc_datapath_swap_dither_timestamp_ctrl dut_u (.*);
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    regAddr <= a;
    regWriteData <= v;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 check({8'h0, regReadData}, {8'h0, exp});
  endtask
  task test_regs;
    rd(12'h09b, 8'h07);
    rd(12'h09d, 8'h00);
    rd(12'h160, 8'h00);
    rd(12'h0f0, 8'h00);
    wr(12'h09b, 8'h1f);
    rd(12'h09b, 8'h1f);
    for (int i = 0; i < 8; i++) begin
      wr(12'h09d, 8'(i));
      @(posedge clk_sys);
      #1 check({13'h0, roundingErrorTarget, ditherAmplitudeSelect, ditherEnable}, 16'(i));
      rd(12'h09d, 8'(i));
    end
    $display("regs done");
  endtask
  task test_stamp;
    int n;
    @(posedge clk_sys) timestampIn <= 1'b1;
    wr(12'h160, 8'h01);
    repeat (8) @(posedge clk_sys);
    #1 check(linkSample0, {12'habc, 4'h1});
    check(linkSample1, {12'h123, 4'h1});
    check(16'(alignControlBits), 16'h0);
    @(posedge clk_sys) coreSampleA <= 12'h456;
    timestampIn <= 1'b0;
    n = 0;
    while (linkSample0[15:4] !== 12'h456 && n < 10) begin
      @(posedge clk_sys);
      #1 n++;
    end
    check(linkSample0, {12'h456, 4'h0});
    check(16'(n), 16'h5);
    wr(12'h160, 8'h00);
    @(posedge clk_sys) timestampIn <= 1'b1;
    repeat (8) @(posedge clk_sys);
    #1 check(linkSample0, {12'h456, 4'h0});
    $display("stamp done");
  endtask
  task test_swap(input logic sw, input logic [7:0] dly, input int lat);
    int n;
    wr(12'h09b, dly);
    @(posedge clk_sys) swapActive <= sw;
    repeat (40) @(posedge clk_sys);
    muxSelect <= ~muxSelect;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1 n++;
    end while (encoderSelect !== muxSelect && n < 60);
    check(16'(n), 16'(lat));
    $display("swap done");
  endtask
  task complete_run;
    $display("checks %0d fails %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    {reset_n, regWrite, regRead, swapActive, muxSelect, timestampIn} = 6'h0;
    {regAddr, regWriteData} = 20'h0;
    coreSampleA = 12'habc;
    coreSampleB = 12'h123;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    test_regs;
    test_stamp;
    test_swap(1'b0, 8'h1f, 5);
    test_swap(1'b1, 8'h1f, 36);
    test_swap(1'b1, 8'h05, 10);
    complete_run;
  end
  initial begin
    #200000;
    miscompares++;
    complete_run;
  end
endmodule
